/* hdl/ahp_pkg.sv */
// shared constants and types for the async host port and its controller
package ahp_pkg;

  // ************************************************************
  // link widths and pin reset values
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // synchroniser idle: strap low, reset high, iack high, cs high, rnw high, sel 0, data FF
  localparam logic [16:0] DEV_PIN_IDLE = 17'h0F0FF;
  // synchroniser idle: irq high, ack high, data FF
  localparam logic [9:0] HOST_PIN_IDLE = 10'h3FF;

  // ************************************************************
  // device register indices (register_select)
  // ************************************************************
  localparam logic [3:0] IDX_MODE_A = 4'h0;
  localparam logic [3:0] IDX_STATUS_A = 4'h1;
  localparam logic [3:0] IDX_MODE_B = 4'h2;
  localparam logic [3:0] IDX_STATUS_B = 4'h3;
  localparam logic [3:0] IDX_IMASK = 4'h4;
  localparam logic [3:0] IDX_ISTAT = 4'h5;
  localparam logic [3:0] IDX_OUT_VALUE = 4'h6;
  localparam logic [3:0] IDX_OUT_CONFIG = 4'h7;
  localparam logic [3:0] IDX_VECTOR = 4'h8;
  localparam logic [3:0] IDX_CTRL = 4'h9;

  // device control register fields and reset values
  localparam int CTRL_TIMER_RUN = 0;
  localparam int CTRL_BREAK_A = 1;
  localparam int CTRL_BREAK_B = 2;
  localparam logic [7:0] VECTOR_RST = 8'h0F; // arbitrary default vector
  localparam logic [7:0] REG_CLEAR = 8'h00;
  localparam logic [7:0] GEN_OUT_RST = 8'hFF;

  // ************************************************************
  // controller AHB-Lite map
  // ************************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam int CMD_RNW_BIT = 4;
  localparam int CMD_IACK_BIT = 5;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_IRQ_BIT = 1;
  localparam int ST_RESET_BIT = 2;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_DEVIRQ_BIT = 1;
  localparam int CTRL_DEVRST_BIT = 0;

  // ************************************************************
  // state machines
  // ************************************************************
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_ACK = 2'b01
  } ahp_dev_state_e;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_WAIT_ACK = 2'b01,
    HOST_WAIT_REL = 2'b10
  } ahp_host_state_e;

endpackage

/* hdl/ahp_bus_if.sv */
// parallel host bus joining controller end and device end
`timescale 1ns/1ps
interface ahp_bus_if;
  logic chip_select_n;
  logic read_not_write;
  logic [3:0] register_select;
  logic irq_acknowledge_n;
  logic reset_n_a;
  logic bus_config;
  logic [7:0] host_data_out;
  logic host_data_oe_n;
  logic [7:0] dev_data_out;
  logic dev_data_oe_n;
  logic transfer_ack_out;
  logic transfer_ack_oe_n;
  logic irq_request_oe_n;
  logic [7:0] host_data_bus;
  logic transfer_ack_n;
  logic irq_request_n;

  // wire levels; undriven lines float to the pull-up level
  assign host_data_bus = !dev_data_oe_n ? dev_data_out :
                         (!host_data_oe_n ? host_data_out : 8'hFF);
  assign transfer_ack_n = transfer_ack_oe_n ? 1'b1 : transfer_ack_out;
  assign irq_request_n = irq_request_oe_n ? 1'b1 : 1'b0;

  modport dev (
    input chip_select_n, read_not_write, register_select, irq_acknowledge_n,
    input reset_n_a, bus_config, host_data_bus,
    output dev_data_out, dev_data_oe_n, transfer_ack_out, transfer_ack_oe_n,
    output irq_request_oe_n
  );

  modport host (
    output chip_select_n, read_not_write, register_select, irq_acknowledge_n,
    output reset_n_a, bus_config, host_data_out, host_data_oe_n,
    input host_data_bus, transfer_ack_n, irq_request_n
  );
endinterface

/* hdl/ahp_device_end.sv */
// device end of the acknowledge-style host port with pin reset effects
// Functional notes
// R1: board strap low selects acknowledge-style bus
// R2: eight-bit tri-state data bus, bit0 LSB
// R3: chip select low transfers; high tri-states bus
// R4: direction high reads, low writes
// R5: interrupt acknowledge drives vector and acknowledge
// R6: host usually acknowledges after interrupt request
// R7: acknowledge low on every completed cycle
// R8: four select lines pick the register
// R9: reset clears status, mask, interrupt, port registers
// R10: reset forces general outputs high
// R11: reset halts timer, idles both channels
// R12: reset holds serial outputs at mark
// R13: reset returns mode pointer to first register
// R14: open-drain interrupt request while unmasked condition
// R15: release bus and acknowledge after cycle ends
// R16: host holds address, direction, data until acknowledge
`timescale 1ns/1ps
module ahp_device_end (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  ahp_bus_if.dev bus,
  input wire logic [7:0] i_status_channel_a,
  input wire logic [7:0] i_status_channel_b,
  input wire logic [7:0] i_irq_event,
  output logic [7:0] o_general_outputs,
  output logic o_serial_out_channel_a,
  output logic o_serial_out_channel_b,
  output logic o_timer_running
);
  import ahp_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [16:0] pin_meta_q;
  logic [16:0] pin_sync_q;
  logic bus_cfg_s;
  logic reset_pin_s;
  logic iack_n_s;
  logic cs_n_s;
  logic rnw_s;
  logic [3:0] sel_s;
  logic [7:0] wdata_s;

  // two stages; only the second stage is decoded
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_meta_q <= DEV_PIN_IDLE;
      pin_sync_q <= DEV_PIN_IDLE;
    end
    else
    begin
      pin_meta_q <= {bus.bus_config, bus.reset_n_a, bus.irq_acknowledge_n,
                     bus.chip_select_n, bus.read_not_write, bus.register_select,
                     bus.host_data_bus};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {bus_cfg_s, reset_pin_s, iack_n_s, cs_n_s, rnw_s, sel_s, wdata_s} = pin_sync_q;

  // ************************************************************
  // register decoding helpers
  // ************************************************************
  // mode index hit, returns {hit, channel}
  function automatic logic [1:0] mode_hit(input logic [3:0] idx);
    logic [1:0] r;
    r = 2'b00;
    if (idx == IDX_MODE_A)
    begin
      r = 2'b10;
    end
    else if (idx == IDX_MODE_B)
    begin
      r = 2'b11;
    end
    return r;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  ahp_dev_state_e st_q, st_d;
  logic [7:0] stat_a_q, stat_a_d, stat_b_q, stat_b_d;
  logic [7:0] imask_q, imask_d, istat_q, istat_d;
  logic [7:0] opr_q, opr_d, output_port_config_q, output_port_config_d;
  logic [7:0] vector_q, vector_d, ctrl_q, ctrl_d;
  logic [7:0] mode_q [2][2];
  logic [7:0] mode_d [2][2];
  logic [1:0] ptr_q, ptr_d;
  logic [7:0] dout_q, dout_d;
  logic dout_oe_n_q, dout_oe_n_d;
  logic ack_oe_n_q, ack_oe_n_d;
  logic irq_oe_n_q, irq_oe_n_d;
  logic [7:0] gen_q, gen_d;
  logic ser_a_q, ser_a_d, ser_b_q, ser_b_d;
  logic timer_q, timer_d;
  logic cycle_req;
  logic [1:0] mhit;

  // read data mux; mode reads follow the channel pointer
  function automatic logic [7:0] read_reg(input logic [3:0] idx);
    logic [1:0] h;
    logic [7:0] r;
    h = mode_hit(idx);
    r = REG_CLEAR;
    if (h[1])
    begin
      r = mode_q[h[0]][ptr_q[h[0]]];
    end
    else
    begin
      case (idx)
        IDX_STATUS_A: r = stat_a_q;
        IDX_STATUS_B: r = stat_b_q;
        IDX_IMASK: r = imask_q;
        IDX_ISTAT: r = istat_q;
        IDX_OUT_VALUE: r = opr_q;
        IDX_OUT_CONFIG: r = output_port_config_q;
        IDX_VECTOR: r = vector_q;
        IDX_CTRL: r = ctrl_q;
        default: r = REG_CLEAR; // unmapped reads as zero
      endcase
    end
    return r;
  endfunction

  // a cycle only counts with the strap in acknowledge-style mode
  assign cycle_req = !bus_cfg_s && (!cs_n_s || !iack_n_s); // [R1] [R3] [R5]
  assign mhit = mode_hit(sel_s); // [R8]

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    st_d = st_q;
    stat_a_d = i_status_channel_a;
    stat_b_d = i_status_channel_b;
    imask_d = imask_q;
    opr_d = opr_q;
    output_port_config_d = output_port_config_q;
    vector_d = vector_q;
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    ptr_d = ptr_q;
    dout_d = dout_q;
    dout_oe_n_d = dout_oe_n_q;
    ack_oe_n_d = ack_oe_n_q;
    istat_d = istat_q;
    case (st_q)
      DEV_IDLE:
      begin
        if (cycle_req)
        begin
          ack_oe_n_d = 1'b0; // [R7]
          st_d = DEV_ACK;
          if (!iack_n_s)
          begin
            dout_d = vector_q; // [R5]
            dout_oe_n_d = 1'b0; // [R2]
          end
          else if (rnw_s)
          begin
            dout_d = read_reg(sel_s); // [R4] [R8]
            dout_oe_n_d = 1'b0; // [R2]
            if (mhit[1])
            begin
              ptr_d[mhit[0]] = 1'b1;
            end
          end
          else
          begin
            // write: data was held stable by the host since select
            if (mhit[1]) // [R16]
            begin
              mode_d[mhit[0]][ptr_q[mhit[0]]] = wdata_s; // [R4]
              ptr_d[mhit[0]] = 1'b1;
            end
            case (sel_s)
              IDX_IMASK: imask_d = wdata_s;
              IDX_ISTAT: istat_d = istat_q & ~wdata_s; // ones clear
              IDX_OUT_VALUE: opr_d = wdata_s;
              IDX_OUT_CONFIG: output_port_config_d = wdata_s;
              IDX_VECTOR: vector_d = wdata_s;
              IDX_CTRL: ctrl_d = wdata_s;
              default: ; // status and unmapped writes ignored
            endcase
          end
        end
      end
      DEV_ACK:
      begin
        // hold until both strobes are gone, then float
        if (cs_n_s && iack_n_s)
        begin
          ack_oe_n_d = 1'b1; // [R15]
          dout_oe_n_d = 1'b1; // [R15] [R3]
          st_d = DEV_IDLE;
        end
      end
      default:
      begin
        st_d = DEV_IDLE;
      end
    endcase
    // event set wins over a same-cycle clear
    istat_d = istat_d | i_irq_event;
    // pin reset overrides everything it names and drops the bus
    if (!reset_pin_s)
    begin
      stat_a_d = REG_CLEAR; // [R9]
      stat_b_d = REG_CLEAR; // [R9]
      imask_d = REG_CLEAR; // [R9]
      istat_d = REG_CLEAR; // [R9]
      opr_d = REG_CLEAR; // [R9]
      output_port_config_d = REG_CLEAR; // [R9]
      ctrl_d = REG_CLEAR; // [R11] [R12]
      ptr_d = 2'b00; // [R13]
      st_d = DEV_IDLE;
      ack_oe_n_d = 1'b1;
      dout_oe_n_d = 1'b1;
    end
    // pins: inverted port value, mark unless break, open-drain irq
    gen_d = ~opr_d; // [R10]
    ser_a_d = ~ctrl_d[CTRL_BREAK_A]; // [R12]
    ser_b_d = ~ctrl_d[CTRL_BREAK_B]; // [R12]
    timer_d = ctrl_d[CTRL_TIMER_RUN]; // [R11]
    irq_oe_n_d = ~|(istat_d & imask_d); // [R14]
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= DEV_IDLE;
      stat_a_q <= REG_CLEAR;
      stat_b_q <= REG_CLEAR;
      imask_q <= REG_CLEAR;
      istat_q <= REG_CLEAR;
      opr_q <= REG_CLEAR;
      output_port_config_q <= REG_CLEAR;
      vector_q <= VECTOR_RST;
      ctrl_q <= REG_CLEAR;
      mode_q <= '{default: REG_CLEAR};
      ptr_q <= 2'b00;
      dout_q <= REG_CLEAR;
      dout_oe_n_q <= 1'b1;
      ack_oe_n_q <= 1'b1;
      irq_oe_n_q <= 1'b1;
      gen_q <= GEN_OUT_RST;
      ser_a_q <= 1'b1;
      ser_b_q <= 1'b1;
      timer_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      stat_a_q <= stat_a_d;
      stat_b_q <= stat_b_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
      opr_q <= opr_d;
      output_port_config_q <= output_port_config_d;
      vector_q <= vector_d;
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      ptr_q <= ptr_d;
      dout_q <= dout_d;
      dout_oe_n_q <= dout_oe_n_d;
      ack_oe_n_q <= ack_oe_n_d;
      irq_oe_n_q <= irq_oe_n_d;
      gen_q <= gen_d;
      ser_a_q <= ser_a_d;
      ser_b_q <= ser_b_d;
      timer_q <= timer_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus.dev_data_out = dout_q;
  assign bus.dev_data_oe_n = dout_oe_n_q;
  assign bus.transfer_ack_out = 1'b0; // only ever drives low
  assign bus.transfer_ack_oe_n = ack_oe_n_q;
  assign bus.irq_request_oe_n = irq_oe_n_q;
  assign o_general_outputs = gen_q;
  assign o_serial_out_channel_a = ser_a_q;
  assign o_serial_out_channel_b = ser_b_q;
  assign o_timer_running = timer_q;

endmodule

/* hdl/ahp_host_end.sv */
// controller end: AHB-Lite registers driving the acknowledge-style host bus
`timescale 1ns/1ps
module ahp_host_end (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_irq,
  ahp_bus_if.host bus
);
  import ahp_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [9:0] pin_meta_q;
  logic [9:0] pin_sync_q;
  logic irq_n_s;
  logic ack_n_s;
  logic [7:0] rdata_s;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_meta_q <= HOST_PIN_IDLE;
      pin_sync_q <= HOST_PIN_IDLE;
    end
    else
    begin
      pin_meta_q <= {bus.irq_request_n, bus.transfer_ack_n, bus.host_data_bus};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {irq_n_s, ack_n_s, rdata_s} = pin_sync_q;

  // ************************************************************
  // state
  // ************************************************************
  ahp_host_state_e st_q, st_d;
  logic pend_q, pend_d, pwrite_q, pwrite_d;
  logic [7:0] paddr_q, paddr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hready_q, hready_d;
  logic [5:0] cmd_q, cmd_d;
  logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] istat_q, istat_d, imask_q, imask_d;
  logic devrst_q, devrst_d, irq_prev_q, irq_q, irq_d;
  logic cs_n_q, cs_n_d, iack_n_q, iack_n_d, rnw_q, rnw_d;
  logic [3:0] sel_q, sel_d;
  logic [7:0] hdout_q, hdout_d;
  logic hdoe_n_q, hdoe_n_d;
  logic [1:0] evt;
  logic go;

  // ************************************************************
  // next state: bus slave, link sequencer, interrupts
  // ************************************************************
  always_comb
  begin
    st_d = st_q;
    pend_d = pend_q;
    pwrite_d = pwrite_q;
    paddr_d = paddr_q;
    hrdata_d = hrdata_q;
    hready_d = hready_q;
    cmd_d = cmd_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    imask_d = imask_q;
    devrst_d = devrst_q;
    cs_n_d = cs_n_q;
    iack_n_d = iack_n_q;
    rnw_d = rnw_q;
    sel_d = sel_q;
    hdout_d = hdout_q;
    hdoe_n_d = hdoe_n_q;
    istat_d = istat_q;
    evt = 2'b00;
    go = 1'b0;
    // first half of a two-cycle data phase: answer and commit
    if (pend_q)
    begin
      pend_d = 1'b0;
      hready_d = 1'b1;
      hrdata_d = 32'h0000_0000;
      if (pwrite_q)
      begin
        case (paddr_q)
          OFS_CMD:
          begin
            cmd_d = i_hwdata[5:0];
            go = (st_q == HOST_IDLE); // busy ignores new orders
          end
          OFS_WDATA: wdata_d = i_hwdata[7:0];
          OFS_INT_STAT: istat_d = istat_q & ~i_hwdata[1:0];
          OFS_INT_MASK: imask_d = i_hwdata[1:0];
          OFS_CTRL: devrst_d = i_hwdata[CTRL_DEVRST_BIT];
          default: ;
        endcase
      end
      else
      begin
        case (paddr_q)
          OFS_CMD: hrdata_d = {26'h0, cmd_q};
          OFS_WDATA: hrdata_d = {24'h0, wdata_q};
          OFS_STATUS: hrdata_d = {29'h0, devrst_q, !irq_n_s, st_q != HOST_IDLE};
          OFS_RDATA: hrdata_d = {24'h0, rdata_q};
          OFS_INT_STAT: hrdata_d = {30'h0, istat_q};
          OFS_INT_MASK: hrdata_d = {30'h0, imask_q};
          OFS_CTRL: hrdata_d = {31'h0, devrst_q};
          default: hrdata_d = 32'h0000_0000;
        endcase
      end
    end
    else if (i_hsel && i_htrans[1] && i_hready)
    begin
      pend_d = 1'b1;
      hready_d = 1'b0;
      pwrite_d = i_hwrite;
      paddr_d = i_haddr[7:0];
    end
    // link sequencer; lines stay put until acknowledge is seen [R16]
    case (st_q)
      HOST_IDLE:
      begin
        if (go)
        begin
          sel_d = i_hwdata[3:0];
          rnw_d = i_hwdata[CMD_RNW_BIT];
          iack_n_d = !i_hwdata[CMD_IACK_BIT];
          cs_n_d = i_hwdata[CMD_IACK_BIT];
          hdout_d = wdata_q;
          hdoe_n_d = i_hwdata[CMD_RNW_BIT] || i_hwdata[CMD_IACK_BIT];
          st_d = HOST_WAIT_ACK;
        end
      end
      HOST_WAIT_ACK:
      begin
        if (!ack_n_s)
        begin
          rdata_d = rdata_s;
          cs_n_d = 1'b1;
          iack_n_d = 1'b1;
          hdoe_n_d = 1'b1;
          st_d = HOST_WAIT_REL;
        end
      end
      HOST_WAIT_REL:
      begin
        if (ack_n_s)
        begin
          evt[INT_DONE_BIT] = 1'b1;
          st_d = HOST_IDLE;
        end
      end
      default:
      begin
        st_d = HOST_IDLE;
      end
    endcase
    evt[INT_DEVIRQ_BIT] = irq_prev_q && !irq_n_s;
    istat_d = istat_d | evt; // set beats clear
    irq_d = |(istat_d & imask_d);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= HOST_IDLE;
      pend_q <= 1'b0;
      pwrite_q <= 1'b0;
      paddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
      cmd_q <= 6'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      istat_q <= 2'h0;
      imask_q <= 2'h0;
      devrst_q <= 1'b0;
      irq_prev_q <= 1'b1;
      irq_q <= 1'b0;
      cs_n_q <= 1'b1;
      iack_n_q <= 1'b1;
      rnw_q <= 1'b1;
      sel_q <= 4'h0;
      hdout_q <= 8'h00;
      hdoe_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      pend_q <= pend_d;
      pwrite_q <= pwrite_d;
      paddr_q <= paddr_d;
      hrdata_q <= hrdata_d;
      hready_q <= hready_d;
      cmd_q <= cmd_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      devrst_q <= devrst_d;
      irq_prev_q <= irq_n_s;
      irq_q <= irq_d;
      cs_n_q <= cs_n_d;
      iack_n_q <= iack_n_d;
      rnw_q <= rnw_d;
      sel_q <= sel_d;
      hdout_q <= hdout_d;
      hdoe_n_q <= hdoe_n_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_hrdata = hrdata_q;
  assign o_hreadyout = hready_q;
  assign o_hresp = 1'b0; // always OKAY
  assign o_irq = irq_q;
  assign bus.chip_select_n = cs_n_q;
  assign bus.irq_acknowledge_n = iack_n_q;
  assign bus.read_not_write = rnw_q;
  assign bus.register_select = sel_q;
  assign bus.host_data_out = hdout_q;
  assign bus.host_data_oe_n = hdoe_n_q;
  assign bus.reset_n_a = !devrst_q;
  assign bus.bus_config = 1'b0; // strap held low [R1]
endmodule

/* verification/ahp_bus_monitor.sv */
// concurrent checks on the parallel host bus between the two ends
`timescale 1ns/1ps
module ahp_bus_monitor (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic chip_select_n,
  input wire logic read_not_write,
  input wire logic [3:0] register_select,
  input wire logic irq_acknowledge_n,
  input wire logic reset_n_a,
  input wire logic bus_config,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic transfer_ack_oe_n,
  input wire logic transfer_ack_n
);
  // ************************************************************
  // bus protocol checks
  // ************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // both strobes at rest; the device sees this two sync stages late
  wire idle = chip_select_n && irq_acknowledge_n;

  bus_release_a: assert property (idle[*6] |-> dev_data_oe_n && transfer_ack_oe_n)
    else $error("bus still driven after strobes released");
  ack_in_cycle_a: assert property ($fell(transfer_ack_oe_n) |-> !idle)
    else $error("acknowledge outside a cycle");
  ack_bound_a: assert property ($fell(chip_select_n) && reset_n_a && !bus_config
    |-> ##[1:8] !transfer_ack_n) else $error("no acknowledge for cycle");
  read_drive_a: assert property (!transfer_ack_oe_n && !chip_select_n && read_not_write
    |-> !dev_data_oe_n) else $error("read acknowledged without data");
  write_drive_a: assert property (!chip_select_n && !read_not_write && irq_acknowledge_n
    |-> dev_data_oe_n && !host_data_oe_n) else $error("wrong data driver in write");
  vector_drive_a: assert property (!irq_acknowledge_n && !transfer_ack_oe_n
    |-> !dev_data_oe_n) else $error("vector not driven");
  addr_hold_a: assert property (!chip_select_n && !$past(chip_select_n)
    |-> $stable(register_select) && $stable(read_not_write)) else $error("address moved");
  host_release_a: assert property (!transfer_ack_n |-> ##[1:6] idle)
    else $error("host kept strobes after acknowledge");
  pin_reset_a: assert property (!reset_n_a [*5] |-> transfer_ack_oe_n && dev_data_oe_n)
    else $error("bus driven during pin reset");

  // main scenarios reached
  cover property (!chip_select_n && read_not_write && !transfer_ack_n);
  cover property (!chip_select_n && !read_not_write && !transfer_ack_n);
  cover property (!irq_acknowledge_n && !transfer_ack_n);
  cover property (!reset_n_a);
endmodule

/* verification/async_host_bus_port_reset_tb.sv */
// self-checking bench joining controller end and device end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module async_host_bus_port_reset_tb;
  import ahp_pkg::*;
  // ************************************************************
  // stimulus, instances and tasks
  // ************************************************************
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] st_a = 8'h00;
  logic [7:0] st_b = 8'h00;
  logic [7:0] irq_ev = 8'h00;
  logic [31:0] hrdata, t;
  logic hready, hresp, irq, ser_a, ser_b, tmr;
  logic [7:0] gen_out, r;
  logic [3:0] idx [5] = '{IDX_IMASK, IDX_OUT_VALUE, IDX_OUT_CONFIG, IDX_ISTAT, IDX_CTRL};
  logic [7:0] val [3] = '{8'h04, 8'h3C, 8'h81};
  int err_count = 0;
  int n_tests = 0;

  ahp_bus_if u_ahp_bus_if ();
  ahp_host_end u_ahp_host_end (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_hsel(1'b1),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_irq(irq), .bus(u_ahp_bus_if));
  ahp_device_end u_ahp_device_end (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .bus(u_ahp_bus_if), .i_status_channel_a(st_a), .i_status_channel_b(st_b),
    .i_irq_event(irq_ev), .o_general_outputs(gen_out), .o_serial_out_channel_a(ser_a),
    .o_serial_out_channel_b(ser_b), .o_timer_running(tmr));
  ahp_bus_monitor u_ahp_bus_monitor (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .chip_select_n(u_ahp_bus_if.chip_select_n), .read_not_write(u_ahp_bus_if.read_not_write),
    .register_select(u_ahp_bus_if.register_select), .reset_n_a(u_ahp_bus_if.reset_n_a),
    .irq_acknowledge_n(u_ahp_bus_if.irq_acknowledge_n), .bus_config(u_ahp_bus_if.bus_config),
    .host_data_oe_n(u_ahp_bus_if.host_data_oe_n), .dev_data_oe_n(u_ahp_bus_if.dev_data_oe_n),
    .transfer_ack_oe_n(u_ahp_bus_if.transfer_ack_oe_n),
    .transfer_ack_n(u_ahp_bus_if.transfer_ack_n));

  // 250 MHz reference
  always #2 i_ref_clk = ~i_ref_clk;

  // one AHB single transfer; read data lands in t
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge i_ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_ref_clk); while (hready !== 1'b1);
    t = hrdata;
  endtask

  // one device bus cycle; polls until idle, only the watchdog ends a hang
  task automatic dev(input logic [5:0] cmd, input logic [7:0] wd);
    ahb(1'b1, OFS_WDATA, {24'h0, wd});
    ahb(1'b1, OFS_CMD, {26'h0, cmd});
    t = 32'h1;
    while (t[ST_BUSY_BIT] !== 1'b0)
      ahb(1'b0, OFS_STATUS, 32'h0);
    ahb(1'b0, OFS_RDATA, 32'h0);
    r = t[7:0];
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    `CHK("gen_out", GEN_OUT_RST, gen_out)
    `CHK("serial", 2'h3, {ser_a, ser_b})
    `CHK("timer", 1'b0, tmr)
    $display("test reset done");
    for (int k = 0; k < 3; k++)
    begin
      dev({2'h0, idx[k]}, val[k]);
      dev({2'h1, idx[k]}, 8'h00);
      `CHK("readback", val[k], r)
    end
    `CHK("gen_out", 8'hC3, gen_out)
    ahb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped", 32'h0, t)
    `CHK("hresp", 1'b0, hresp)
    st_a <= 8'h5A;
    st_b <= 8'hA5;
    dev({2'h1, IDX_STATUS_A}, 8'h00);
    `CHK("status_a", 8'h5A, r)
    dev({2'h1, IDX_STATUS_B}, 8'h00);
    `CHK("status_b", 8'hA5, r)
    dev({2'h0, IDX_CTRL}, 8'h07);
    `CHK("run", 3'h4, {tmr, ser_a, ser_b})
    dev({2'h0, IDX_MODE_A}, 8'h11);
    dev({2'h0, IDX_MODE_A}, 8'h22);
    dev({2'h0, IDX_MODE_B}, 8'h33);
    $display("test access done");
    irq_ev <= 8'h04;
    @(posedge i_ref_clk);
    irq_ev <= 8'h00;
    repeat (6) @(posedge i_ref_clk);
    `CHK("irq masked", 1'b0, irq)
    ahb(1'b1, OFS_INT_MASK, 32'h2);
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("dev irq", 1'b1, t[ST_IRQ_BIT])
    `CHK("irq", 1'b1, irq)
    dev(6'h20, 8'h00);
    `CHK("vector", VECTOR_RST, r)
    dev({2'h0, IDX_ISTAT}, 8'h04);
    ahb(1'b1, OFS_INT_STAT, 32'h3);
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("dev irq off", 1'b0, t[ST_IRQ_BIT])
    `CHK("irq off", 1'b0, irq)
    $display("test interrupt done");
    // device pin reset held by the controller, effects lag the synchroniser
    irq_ev <= 8'h01;
    @(posedge i_ref_clk);
    irq_ev <= 8'h00;
    ahb(1'b1, OFS_CTRL, 32'h1);
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("dev reset", 1'b1, t[ST_RESET_BIT])
    repeat (5) @(posedge i_ref_clk);
    `CHK("gen_out rst", GEN_OUT_RST, gen_out)
    `CHK("stop", 3'h3, {tmr, ser_a, ser_b})
    ahb(1'b1, OFS_CTRL, 32'h0);
    repeat (5) @(posedge i_ref_clk);
    for (int k = 0; k < 5; k++)
    begin
      dev({2'h1, idx[k]}, 8'h00);
      `CHK("cleared", REG_CLEAR, r)
    end
    dev({2'h1, IDX_MODE_A}, 8'h00);
    `CHK("mode first", 8'h11, r)
    dev({2'h1, IDX_MODE_B}, 8'h00);
    `CHK("mode b first", 8'h33, r)
    $display("test pin reset done");
    test_done();
  end

  // watchdog well past the expected run length
  initial
  begin
    repeat (30000) @(posedge i_ref_clk);
    err_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule
